/* amp_control_register_bank.sv */
`timescale 1ns/1ps
// Behaviour
// - auto sleep enabled: 2048 consecutive zero samples put the amplifier in low power
// - while auto asleep with master sleep clear, one nonzero sample returns it to normal operation
// - bit 6 of power control set switches supply sensing off
// - writing 1 to power control bit 1 resets all blocks and the writable registers; the supply and fault readouts keep tracking their inputs
// - master sleep bit 0 resets to 1 and holds blocks in low power
// - edge bit 4: 0 normal edges, 1 slow low-emission edges
// - full-scale codes 00..11 give 8.4, 12.6, 14, 15 V; resets to 01
module amp_control_register_bank
  import amp_regs_pkg::*;
#(
  parameter int SAMPLE_WIDTH = AUDIO_WIDTH,
  parameter int RUN_LEN = ZERO_RUN_LEN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic sample_valid,
  input wire logic [SAMPLE_WIDTH-1:0] sample_data,
  input wire logic [7:0] supply_voltage_in,
  input wire logic [7:0] fault_status_in,
  output logic master_sleep,
  output logic auto_asleep,
  output logic powered_down,
  output logic supply_sense_off,
  output logic edge_slow,
  output logic [1:0] analog_fullscale_sel,
  output logic [15:0] fullscale_mv,
  output logic block_reset,
  output logic [7:0] converter_control,
  output logic [7:0] volume_control,
  output logic [7:0] serial_audio_control_a,
  output logic [7:0] serial_audio_control_b,
  output logic [7:0] limiter_control_a,
  output logic [7:0] limiter_control_b,
  output logic [7:0] limiter_control_c,
  output logic [7:0] fault_recovery_control
);

  logic [7:0] cfg [REG_COUNT];
  logic [7:0] supply_meta;
  logic [7:0] supply_sync;
  logic [7:0] fault_meta;
  logic [7:0] fault_sync;
  logic [7:0] supply_prev;
  logic [7:0] supply_held;
  logic supply_steady;
  logic [REG_COUNT-1:0] write_hit;
  logic [7:0] power_control;
  logic [7:0] gain_edge_control;
  logic in_range;
  logic soft_reset_hit;
  logic [7:0] read_value;
  logic [7:0] write_value;
  amp_sleep_if sleep_link ();

  function automatic logic is_writable(input logic [7:0] a);
    return a != REG_SUPPLY_VOLTAGE_READOUT && a != REG_FAULT_STATUS;
  endfunction

  assign in_range = addr < 8'(REG_COUNT);
  assign soft_reset_hit = wr_en && addr == REG_POWER_CONTROL && wr_data[SOFT_RESET_BIT];
  // soft reset bit is never stored, so it reads 0 and can fire again
  assign write_value = (addr == REG_POWER_CONTROL) ? (wr_data & ~SOFT_RESET_MASK) : wr_data;
  // a read in the write cycle returns the old contents
  assign read_value = !in_range ? 8'h00 :
                      (addr == REG_SUPPLY_VOLTAGE_READOUT) ? supply_held :
                      (addr == REG_FAULT_STATUS) ? fault_sync : cfg[addr[3:0]];

  // one write strobe per register; read-only and unmapped offsets get none
  for (genvar g = 0; g < REG_COUNT; g++) begin : g_write_hit
    assign write_hit[g] = wr_en && in_range && addr == 8'(g) && is_writable(8'(g));
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < REG_COUNT; i++) begin
      if (!rst_n || soft_reset_hit) begin
        cfg[i] <= RESET_VALUES[i];
      end else if (write_hit[i]) begin
        cfg[i] <= write_value;
      end
    end
  end

  // status inputs come from the analog side, so they are synchronised
  // the supply word is taken only once two samples agree: no torn readout,
  // at the cost of two more clocks of latency than the fault path
  // fault flags are independent bits, so two flip-flops are enough for them
  assign supply_steady = supply_sync == supply_prev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      supply_meta <= 8'h00;
      supply_sync <= 8'h00;
      supply_prev <= 8'h00;
      supply_held <= 8'h00;
      fault_meta <= 8'h00;
      fault_sync <= 8'h00;
    end else begin
      supply_meta <= supply_voltage_in;
      supply_sync <= supply_meta;
      supply_prev <= supply_sync;
      supply_held <= supply_steady ? supply_sync : supply_held;
      fault_meta <= fault_status_in;
      fault_sync <= fault_meta;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      block_reset <= 1'b0;
    end else begin
      rd_data <= rd_en ? read_value : rd_data;
      rd_valid <= rd_en;
      block_reset <= soft_reset_hit;
    end
  end

  assign power_control = cfg[REG_POWER_CONTROL[3:0]];
  assign gain_edge_control = cfg[REG_GAIN_EDGE_CONTROL[3:0]];

  assign sleep_link.enable = power_control[AUTO_SLEEP_ENABLE_BIT];
  assign sleep_link.clear = soft_reset_hit || block_reset;
  assign sleep_link.sample_valid = sample_valid;
  assign sleep_link.sample_zero = sample_data == '0;

  zero_run_detector #(
    .RUN_LEN(RUN_LEN)
  ) detector (
    .clk(clk),
    .rst_n(rst_n),
    .link(sleep_link.detector)
  );

  assign master_sleep = power_control[MASTER_SLEEP_BIT];
  assign auto_asleep = sleep_link.asleep;
  // control bus stays awake in either low power state
  assign powered_down = master_sleep || auto_asleep;
  assign supply_sense_off = power_control[SUPPLY_SENSE_OFF_BIT];
  assign edge_slow = gain_edge_control[EDGE_SLOW_BIT];
  assign analog_fullscale_sel =
    gain_edge_control[FULLSCALE_LSB +: FULLSCALE_WIDTH];
  assign fullscale_mv = FULLSCALE_MV[analog_fullscale_sel];
  assign converter_control = cfg[REG_CONVERTER_CONTROL[3:0]];
  assign volume_control = cfg[REG_VOLUME_CONTROL[3:0]];
  assign serial_audio_control_a = cfg[REG_SERIAL_AUDIO_CONTROL_A[3:0]];
  assign serial_audio_control_b = cfg[REG_SERIAL_AUDIO_CONTROL_B[3:0]];
  assign limiter_control_a = cfg[REG_LIMITER_CONTROL_A[3:0]];
  assign limiter_control_b = cfg[REG_LIMITER_CONTROL_B[3:0]];
  assign limiter_control_c = cfg[REG_LIMITER_CONTROL_C[3:0]];
  assign fault_recovery_control = cfg[REG_FAULT_RECOVERY_CONTROL[3:0]];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sense_off_write_a: assert property (
    wr_en && addr == REG_POWER_CONTROL && !wr_data[SOFT_RESET_BIT]
    |=> supply_sense_off == $past(wr_data[SUPPLY_SENSE_OFF_BIT]))
    else $error("supply sense off does not follow power control bit 6");
  soft_reset_defaults_a: assert property (
    soft_reset_hit |=> block_reset && master_sleep && volume_control == 8'h40
      && converter_control == 8'h32 && analog_fullscale_sel == 2'h1)
    else $error("soft reset did not restore defaults");
  master_sleep_power_a: assert property (
    master_sleep |-> powered_down)
    else $error("master sleep set but blocks not powered down");
  master_wake_a: assert property (
    wr_en && addr == REG_POWER_CONTROL && wr_data == 8'h00 |=> !master_sleep
      && powered_down == auto_asleep)
    else $error("clearing master sleep did not restore operation");
  edge_rate_write_a: assert property (
    wr_en && addr == REG_GAIN_EDGE_CONTROL |=> edge_slow == $past(wr_data[EDGE_SLOW_BIT]))
    else $error("edge rate does not follow its field");
  fullscale_map_a: assert property (
    (analog_fullscale_sel == 2'h0 && fullscale_mv == 16'd8400)
    || (analog_fullscale_sel == 2'h1 && fullscale_mv == 16'd12600)
    || (analog_fullscale_sel == 2'h2 && fullscale_mv == 16'd14000)
    || (analog_fullscale_sel == 2'h3 && fullscale_mv == 16'd15000))
    else $error("full-scale mapping wrong");
  reset_bit_reads_zero_a: assert property (
    rd_en && addr == REG_POWER_CONTROL |=> rd_valid && !rd_data[SOFT_RESET_BIT])
    else $error("soft reset bit read back as 1");
  reset_pulse_short_a: assert property (
    block_reset && !$past(soft_reset_hit, 1) |-> 1'b0)
    else $error("block reset without a soft reset write");
  reset_pulse_end_a: assert property (
    block_reset && !soft_reset_hit |=> !block_reset)
    else $error("block reset pulse longer than one cycle");
  soft_bit_unstored_a: assert property (
    !power_control[SOFT_RESET_BIT])
    else $error("soft reset bit held in power control");
  auto_sleep_off_a: assert property (
    !sleep_link.enable |=> !auto_asleep)
    else $error("auto sleep active while disabled");
  auto_wake_power_a: assert property (
    auto_asleep && !master_sleep && !wr_en && sample_valid && sample_data != '0
    |=> !powered_down)
    else $error("nonzero sample did not power the amplifier up");
  soft_reset_discard_a: assert property (
    soft_reset_hit |=> !supply_sense_off && !edge_slow && !auto_asleep
      && fault_recovery_control == RESET_VALUES[REG_FAULT_RECOVERY_CONTROL[3:0]])
    else $error("soft reset kept written values");
  master_sleep_write_a: assert property (
    wr_en && addr == REG_POWER_CONTROL
    |=> master_sleep == ($past(wr_data[MASTER_SLEEP_BIT]) || $past(wr_data[SOFT_RESET_BIT])))
    else $error("master sleep does not follow its field");
  master_hold_a: assert property (
    master_sleep && !wr_en |=> master_sleep)
    else $error("master sleep left without a write");
  gain_write_a: assert property (
    wr_en && addr == REG_GAIN_EDGE_CONTROL
    |=> analog_fullscale_sel == $past(wr_data[FULLSCALE_LSB +: FULLSCALE_WIDTH]))
    else $error("full-scale selection does not follow its field");
  edge_hold_a: assert property (
    !wr_en |=> $stable(edge_slow))
    else $error("edge rate changed without a write");
  soft_reset_cover_c: cover property (soft_reset_hit ##1 block_reset);
  auto_sleep_cover_c: cover property (!master_sleep && auto_asleep);
  status_read_cover_c: cover property (rd_en && addr == REG_FAULT_STATUS);

endmodule

/* amp_regs_pkg.sv */
package amp_regs_pkg;

  localparam int REG_COUNT = 12;
  localparam logic [7:0] REG_POWER_CONTROL = 8'h00;
  localparam logic [7:0] REG_GAIN_EDGE_CONTROL = 8'h01;
  localparam logic [7:0] REG_CONVERTER_CONTROL = 8'h02;
  localparam logic [7:0] REG_VOLUME_CONTROL = 8'h03;
  localparam logic [7:0] REG_SERIAL_AUDIO_CONTROL_A = 8'h04;
  localparam logic [7:0] REG_SERIAL_AUDIO_CONTROL_B = 8'h05;
  localparam logic [7:0] REG_SUPPLY_VOLTAGE_READOUT = 8'h06;
  localparam logic [7:0] REG_LIMITER_CONTROL_A = 8'h07;
  localparam logic [7:0] REG_LIMITER_CONTROL_B = 8'h08;
  localparam logic [7:0] REG_LIMITER_CONTROL_C = 8'h09;
  localparam logic [7:0] REG_FAULT_STATUS = 8'h0A;
  localparam logic [7:0] REG_FAULT_RECOVERY_CONTROL = 8'h0B;

  localparam logic [7:0] RESET_VALUES [REG_COUNT] = '{
    8'h81, 8'h01, 8'h32, 8'h40, 8'h11, 8'h00,
    8'h00, 8'hA4, 8'h51, 8'h22, 8'h00, 8'h18
  };

  // power_control fields
  localparam int AUTO_SLEEP_ENABLE_BIT = 7;
  localparam int SUPPLY_SENSE_OFF_BIT = 6;
  localparam int SOFT_RESET_BIT = 1;
  localparam int MASTER_SLEEP_BIT = 0;
  localparam logic [7:0] SOFT_RESET_MASK = 8'h02;

  // gain_edge_control fields
  localparam int EDGE_SLOW_BIT = 4;
  localparam int FULLSCALE_LSB = 0;
  localparam int FULLSCALE_WIDTH = 2;

  // full-scale output in millivolts per analog_fullscale_sel code
  localparam logic [15:0] FULLSCALE_MV [4] = '{16'h20D0, 16'h3138, 16'h36B0, 16'h3A98};

  localparam int ZERO_RUN_LEN = 2048;
  localparam int ZERO_COUNT_WIDTH = 12;
  localparam int AUDIO_WIDTH = 24;

endpackage

/* amp_sleep_if.sv */
`timescale 1ns/1ps
interface amp_sleep_if;
  logic enable;
  logic clear;
  logic sample_valid;
  logic sample_zero;
  logic asleep;

  modport detector(input enable, input clear, input sample_valid, input sample_zero,
    output asleep);
  modport control(output enable, output clear, output sample_valid, output sample_zero,
    input asleep);
endinterface

/* zero_run_detector.sv */
`timescale 1ns/1ps
module zero_run_detector
  import amp_regs_pkg::*;
#(
  parameter int RUN_LEN = ZERO_RUN_LEN
) (
  input wire logic clk,
  input wire logic rst_n,
  amp_sleep_if.detector link
);

  logic [ZERO_COUNT_WIDTH-1:0] count;
  logic asleep;
  logic [ZERO_COUNT_WIDTH-1:0] next_count;
  logic next_asleep;
  logic run_done;

  localparam logic [ZERO_COUNT_WIDTH-1:0] LAST = ZERO_COUNT_WIDTH'(RUN_LEN - 1);

  // count saturates; a nonzero sample always restarts the run
  assign run_done = link.sample_valid && link.sample_zero && (count == LAST);
  assign next_count = (!link.enable || link.clear) ? '0 :
                      !link.sample_valid ? count :
                      !link.sample_zero ? '0 :
                      (count == LAST) ? count : count + 1'b1;
  assign next_asleep = (!link.enable || link.clear) ? 1'b0 :
                       (link.sample_valid && !link.sample_zero) ? 1'b0 :
                       run_done ? 1'b1 : asleep;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
      asleep <= 1'b0;
    end else begin
      count <= next_count;
      asleep <= next_asleep;
    end
  end

  assign link.asleep = asleep;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  zero_run_sleep_a: assert property (
    link.enable && !link.clear && run_done |=> asleep)
    else $error("zero run did not put the amplifier to sleep");
  early_sleep_a: assert property (
    !asleep && link.enable && !link.clear && !run_done |=> !asleep)
    else $error("sleep entered before the zero run completed");
  nonzero_wake_a: assert property (
    link.sample_valid && !link.sample_zero |=> !asleep && count == '0)
    else $error("nonzero sample did not wake the amplifier");
  sleep_cover_c: cover property (run_done ##1 asleep);
  wake_cover_c: cover property (asleep ##[1:20] !asleep);

endmodule

/* host_model.sv */
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
  end
  // one-cycle strobe; released lines are inverted, never left on the old value
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(posedge clk);
    #1 wr_en = 1'b0;
    addr = ~a;
    wr_data = ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    #1 rd_en = 1'b1;
    addr = a;
    @(posedge clk);
    #1 rd_en = 1'b0;
    addr = ~a;
    d = rd_data;
    ok = rd_valid;
  endtask
endmodule

/* amp_control_register_bank_test.sv */
`timescale 1ns/1ps
module amp_control_register_bank_test;
  import amp_regs_pkg::*;
  localparam int RUN = 8;
  logic clk, rst_n, wr_en, rd_en, rd_valid, sample_valid, master_sleep, auto_asleep;
  logic powered_down, supply_sense_off, edge_slow, block_reset, ok;
  logic [7:0] addr, wr_data, rd_data, supply_voltage_in, fault_status_in, d;
  logic [23:0] sample_data;
  logic [1:0] analog_fullscale_sel;
  logic [15:0] fullscale_mv;
  logic [7:0] ctl_out [8];
  int n_errors = 0;
  int num_checks = 0;
  host_model host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid));
  amp_control_register_bank #(.RUN_LEN(RUN)) dut (.clk(clk), .rst_n(rst_n), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .supply_voltage_in(supply_voltage_in), .fault_status_in(fault_status_in),
    .master_sleep(master_sleep), .auto_asleep(auto_asleep), .powered_down(powered_down),
    .supply_sense_off(supply_sense_off), .edge_slow(edge_slow),
    .analog_fullscale_sel(analog_fullscale_sel), .fullscale_mv(fullscale_mv),
    .block_reset(block_reset), .converter_control(ctl_out[0]), .volume_control(ctl_out[1]),
    .serial_audio_control_a(ctl_out[2]), .serial_audio_control_b(ctl_out[3]),
    .limiter_control_a(ctl_out[4]), .limiter_control_b(ctl_out[5]),
    .limiter_control_c(ctl_out[6]), .fault_recovery_control(ctl_out[7]));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, d, ok);
    check("rd_valid", 16'h0001, {15'h0, ok});
    check($sformatf("reg %h", a), {8'h00, exp}, {8'h00, d});
  endtask
  task automatic outputs_check();
    logic [7:0] exp [8] = '{8'h32, 8'h40, 8'h11, 8'h00, 8'hA4, 8'h51, 8'h22, 8'h18};
    for (int i = 0; i < 8; i++) begin
      check($sformatf("control out %0d", i), {8'h00, exp[i]}, {8'h00, ctl_out[i]});
    end
  endtask
  task automatic t_reset_map();
    logic [7:0] exp [13] = '{8'h81, 8'h01, 8'h32, 8'h40, 8'h11, 8'h00, 8'h5A, 8'hA4,
      8'h51, 8'h22, 8'h3C, 8'h18, 8'h00};
    check("master_sleep", 16'h0001, {15'h0, master_sleep});
    check("powered_down", 16'h0001, {15'h0, powered_down});
    for (int i = 0; i < 13; i++) read_check(i[7:0], exp[i]);
    outputs_check();
    $display("reset map done");
  endtask
  task automatic t_gain_edge();
    logic [15:0] mv [4] = '{16'd8400, 16'd12600, 16'd14000, 16'd15000};
    for (int c = 0; c < 4; c++) begin
      host.write_reg(8'h01, {6'b000100, c[1:0]});
      check("edge_slow", 16'h0001, {15'h0, edge_slow});
      check("analog_fullscale_sel", {14'h0, c[1:0]}, {14'h0, analog_fullscale_sel});
      check("fullscale_mv", mv[c], fullscale_mv);
    end
    host.write_reg(8'h01, 8'hE2);
    check("edge_slow", 16'h0000, {15'h0, edge_slow});
    read_check(8'h01, 8'hE2);
    $display("gain and edge done");
  endtask
  task automatic t_power();
    host.write_reg(8'h00, 8'h40);
    check("supply_sense_off", 16'h0001, {15'h0, supply_sense_off});
    check("master_sleep", 16'h0000, {15'h0, master_sleep});
    check("powered_down", 16'h0000, {15'h0, powered_down});
    read_check(8'h00, 8'h40);
    host.write_reg(8'h00, 8'h01);
    check("supply_sense_off", 16'h0000, {15'h0, supply_sense_off});
    check("powered_down", 16'h0001, {15'h0, powered_down});
    $display("power control done");
  endtask
  task automatic t_soft_reset();
    for (int i = 2; i < 12; i++) host.write_reg(i[7:0], 8'hC3);
    check("volume_control", 16'h00C3, {8'h00, ctl_out[1]});
    read_check(8'h06, 8'h5A);
    read_check(8'h0A, 8'h3C);
    host.write_reg(8'h01, 8'h13);
    host.write_reg(8'h00, 8'h42);
    check("block_reset", 16'h0001, {15'h0, block_reset});
    check("supply_sense_off", 16'h0000, {15'h0, supply_sense_off});
    check("edge_slow", 16'h0000, {15'h0, edge_slow});
    @(posedge clk);
    #1 check("block_reset", 16'h0000, {15'h0, block_reset});
    read_check(8'h00, 8'h81);
    read_check(8'h01, 8'h01);
    outputs_check();
    $display("soft reset done");
  endtask
  task automatic send(input logic [23:0] v);
    @(posedge clk);
    #1 sample_valid = 1'b1;
    sample_data = v;
    @(posedge clk);
    #1 sample_valid = 1'b0;
    sample_data = ~v;
    @(posedge clk);
    #1;
  endtask
  task automatic t_auto_sleep();
    host.write_reg(8'h00, 8'h80);
    for (int i = 0; i < RUN - 1; i++) send(24'h000000);
    check("auto_asleep", 16'h0000, {15'h0, auto_asleep});
    send(24'h000000);
    check("auto_asleep", 16'h0001, {15'h0, auto_asleep});
    check("powered_down", 16'h0001, {15'h0, powered_down});
    send(24'h000100);
    check("auto_asleep", 16'h0000, {15'h0, auto_asleep});
    check("powered_down", 16'h0000, {15'h0, powered_down});
    for (int i = 0; i < RUN - 1; i++) send(24'h000000);
    send(24'h800000);
    for (int i = 0; i < RUN - 1; i++) send(24'h000000);
    check("auto_asleep", 16'h0000, {15'h0, auto_asleep});
    $display("auto sleep done");
  endtask
  task automatic t_mid_reset();
    send(24'h000000);
    check("auto_asleep", 16'h0001, {15'h0, auto_asleep});
    host.write_reg(8'h01, 8'h12);
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    check("master_sleep", 16'h0001, {15'h0, master_sleep});
    check("auto_asleep", 16'h0000, {15'h0, auto_asleep});
    check("analog_fullscale_sel", 16'h0001, {14'h0, analog_fullscale_sel});
    check("edge_slow", 16'h0000, {15'h0, edge_slow});
    outputs_check();
    read_check(8'h00, 8'h81);
    $display("mid-run reset done");
  endtask
  initial begin
    // span covers all tests with a wide margin
    #20000;
    n_errors++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    sample_valid = 1'b0;
    sample_data = 24'h000000;
    supply_voltage_in = 8'h5A;
    fault_status_in = 8'h3C;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset_map();
    t_gain_edge();
    t_power();
    t_soft_reset();
    t_auto_sleep();
    t_mid_reset();
    stop_test();
  end
endmodule
